// ==== hw/cid_decoder.sv ====
// Instruction decoder and execute stage of the 16-bit core
`include "cid_defs.svh"
`default_nettype none
module cid_decoder (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // First opcode byte from fetch, for early length
   input wire logic [7:0] fetch_byte,
   output logic [2:0] fetch_len,
   // Instruction with operands
   input wire logic in_valid,
   input wire cid_pkg::cid_operands_t in_ops,
   // Results
   output logic out_valid,
   output cid_pkg::cid_result_t out_res
);
   logic valid_ff;
   logic nxt_valid;
   cid_pkg::cid_result_t res_ff;
   cid_pkg::cid_result_t nxt_res;
   cid_pkg::cid_op_t op;
   logic [7:0] b0;
   logic is_byte;
   logic [15:0] a;
   logic [15:0] b;
   logic [15:0] aw;
   logic [15:0] bw;
   logic [15:0] cin_w;
   logic [16:0] sum;
   logic [16:0] dif;
   logic [15:0] lgc;
   logic [31:0] prod;
   logic [4:0] norm_cnt;
   logic [3:0] sh;
   logic [7:0] mask;

   function automatic logic [2:0] len_of(input logic [7:0] opb);
      logic [5:0] code;
      code = opb[`CID_OP_MSB:`CID_OP_LSB];
      len_of = `CID_LEN_LONG;
      if (code >= 6'(cid_pkg::cid_op_count)) begin
         len_of = `CID_LEN_SHORT;
      end else begin
         case (cid_pkg::cid_op_t'(code))
            cid_pkg::cid_sum, cid_pkg::cid_sum_carry, cid_pkg::cid_diff,
            cid_pkg::cid_diff_borrow, cid_pkg::cid_and, cid_pkg::cid_or, cid_pkg::cid_xor,
            cid_pkg::cid_cmp, cid_pkg::cid_cmp_dec1, cid_pkg::cid_cmp_dec2,
            cid_pkg::cid_cmp_inc1, cid_pkg::cid_cmp_inc2, cid_pkg::cid_mov,
            cid_pkg::cid_widen_s, cid_pkg::cid_widen_z, cid_pkg::cid_ext_seq: begin
               // Variable forms pick length from the long bit
               len_of = opb[`CID_LONG_BIT] ? `CID_LEN_LONG : `CID_LEN_SHORT;
            end
            cid_pkg::cid_prod, cid_pkg::cid_prod_u, cid_pkg::cid_quo, cid_pkg::cid_quo_u,
            cid_pkg::cid_quo_long, cid_pkg::cid_quo_long_u, cid_pkg::cid_compl,
            cid_pkg::cid_negate, cid_pkg::cid_bit_clr, cid_pkg::cid_bit_set,
            cid_pkg::cid_norm, cid_pkg::cid_shl, cid_pkg::cid_shr, cid_pkg::cid_rotl,
            cid_pkg::cid_rotr, cid_pkg::cid_sshr, cid_pkg::cid_push, cid_pkg::cid_pop,
            cid_pkg::cid_return, cid_pkg::cid_return_pop, cid_pkg::cid_nop: begin
               len_of = `CID_LEN_SHORT;
            end
            default: len_of = `CID_LEN_LONG;
         endcase
      end
   endfunction

   // Combinational so fetch can advance before execution
   assign fetch_len = len_of(fetch_byte);

   always_comb begin
      b0 = in_ops.instr[31:24];
      if (b0[`CID_OP_MSB:`CID_OP_LSB] < 6'(cid_pkg::cid_op_count)) begin
         op = cid_pkg::cid_op_t'(b0[`CID_OP_MSB:`CID_OP_LSB]);
      end else begin
         op = cid_pkg::cid_nop;
      end
      is_byte = b0[`CID_BYTE_BIT];
      a = in_ops.dst_val;
      b = in_ops.src_val;
      mask = in_ops.instr[15:8];
      sh = b[3:0];
      // Byte operands run in the upper lane so flags come from bit 15
      aw = is_byte ? {a[7:0], 8'h00} : a;
      bw = is_byte ? {b[7:0], 8'h00} : b;
      cin_w = '0;
      if (op == cid_pkg::cid_sum_carry || op == cid_pkg::cid_diff_borrow) begin
         cin_w = is_byte ? {7'h00, in_ops.carry_in, 8'h00} : {15'h0000, in_ops.carry_in};
      end
      sum = {1'b0, aw} + {1'b0, bw} + {1'b0, cin_w};
      dif = {1'b0, aw} - {1'b0, bw} - {1'b0, cin_w};
      case (op)
         cid_pkg::cid_and: lgc = aw & bw;
         cid_pkg::cid_or: lgc = aw | bw;
         default: lgc = aw ^ bw;
      endcase
      if (op == cid_pkg::cid_prod) begin
         prod = 32'($signed(a) * $signed(b));
      end else begin
         prod = {16'h0000, a} * {16'h0000, b};
      end
      norm_cnt = '0;
      for (int i = 0; i < 16; i++) begin
         if (b[i]) begin
            norm_cnt = 5'(`CID_WORD_MSB - i);
         end
      end
   end

   always_comb begin
      nxt_valid = in_valid;
      nxt_res = '0;
      nxt_res.sub_op = in_ops.instr[23:16];
      nxt_res.target = in_ops.instr[15:0];
      if (b0[`CID_OP_MSB:`CID_OP_LSB] >= 6'(cid_pkg::cid_op_count)) begin
         nxt_res.illegal = 1'b1;
      end
      case (op)
         cid_pkg::cid_sum, cid_pkg::cid_sum_carry: begin
            nxt_res.wr_en = 1'b1;
            nxt_res.wr_byte = is_byte;
            nxt_res.wr_data = is_byte ? {8'h00, sum[15:8]} : sum[15:0];
            nxt_res.flags_wr = 1'b1;
            nxt_res.flags.c = sum[16];
            nxt_res.flags.z = (sum[15:0] == '0);
            nxt_res.flags.n = sum[15];
            nxt_res.flags.v = (aw[15] == bw[15]) && (sum[15] != aw[15]);
         end
         cid_pkg::cid_diff, cid_pkg::cid_diff_borrow, cid_pkg::cid_cmp: begin
            nxt_res.wr_en = (op != cid_pkg::cid_cmp);
            nxt_res.wr_byte = is_byte;
            nxt_res.wr_data = is_byte ? {8'h00, dif[15:8]} : dif[15:0];
            nxt_res.flags_wr = 1'b1;
            nxt_res.flags.c = dif[16];
            nxt_res.flags.z = (dif[15:0] == '0);
            nxt_res.flags.n = dif[15];
            nxt_res.flags.v = (aw[15] != bw[15]) && (dif[15] != aw[15]);
         end
         cid_pkg::cid_cmp_dec1, cid_pkg::cid_cmp_dec2,
         cid_pkg::cid_cmp_inc1, cid_pkg::cid_cmp_inc2: begin
            // Flags from the compare, register takes the stepped value
            nxt_res.flags_wr = 1'b1;
            nxt_res.flags.c = dif[16];
            nxt_res.flags.z = (a == b);
            nxt_res.flags.n = dif[15];
            nxt_res.flags.v = (a[15] != b[15]) && (dif[15] != a[15]);
            nxt_res.wr_en = 1'b1;
            case (op)
               cid_pkg::cid_cmp_dec1: nxt_res.wr_data = a - `CID_STEP_ONE;
               cid_pkg::cid_cmp_dec2: nxt_res.wr_data = a - `CID_STEP_TWO;
               cid_pkg::cid_cmp_inc1: nxt_res.wr_data = a + `CID_STEP_ONE;
               default: nxt_res.wr_data = a + `CID_STEP_TWO;
            endcase
         end
         cid_pkg::cid_prod, cid_pkg::cid_prod_u: begin
            nxt_res.pair_wr = 1'b1;
            nxt_res.pair_data = prod;
            nxt_res.flags_wr = 1'b1;
            nxt_res.flags.z = (prod == '0);
            nxt_res.flags.n = prod[31];
         end
         cid_pkg::cid_quo, cid_pkg::cid_quo_u, cid_pkg::cid_quo_long, cid_pkg::cid_quo_long_u: begin
            nxt_res.flags_wr = 1'b1;
            // Zero divisor leaves the pair alone and raises overflow
            if (b == '0) begin
               nxt_res.flags.v = 1'b1;
            end else begin
               nxt_res.pair_wr = 1'b1;
               case (op)
                  cid_pkg::cid_quo: nxt_res.pair_data = {
                     16'($signed(in_ops.pair_val[15:0]) % $signed(b)),
                     16'($signed(in_ops.pair_val[15:0]) / $signed(b))};
                  cid_pkg::cid_quo_u: nxt_res.pair_data = {
                     in_ops.pair_val[15:0] % b, in_ops.pair_val[15:0] / b};
                  cid_pkg::cid_quo_long: nxt_res.pair_data = {
                     16'($signed(in_ops.pair_val) % $signed(b)),
                     16'($signed(in_ops.pair_val) / $signed(b))};
                  default: nxt_res.pair_data = {
                     16'(in_ops.pair_val % b), 16'(in_ops.pair_val / b)};
               endcase
               nxt_res.flags.z = (nxt_res.pair_data[15:0] == '0);
               nxt_res.flags.n = nxt_res.pair_data[15];
            end
         end
         cid_pkg::cid_compl, cid_pkg::cid_negate, cid_pkg::cid_and, cid_pkg::cid_or,
         cid_pkg::cid_xor: begin
            nxt_res.wr_en = 1'b1;
            nxt_res.wr_byte = is_byte;
            nxt_res.flags_wr = 1'b1;
            if (op == cid_pkg::cid_compl) begin
               nxt_res.wr_data = is_byte ? {8'h00, ~a[7:0]} : ~a;
            end else if (op == cid_pkg::cid_negate) begin
               nxt_res.wr_data = is_byte ? {8'h00, 8'(-a[7:0])} : 16'(-a);
            end else begin
               nxt_res.wr_data = is_byte ? {8'h00, lgc[15:8]} : lgc;
            end
            nxt_res.flags.z = is_byte ? (nxt_res.wr_data[7:0] == '0) : (nxt_res.wr_data == '0);
            nxt_res.flags.n = is_byte ? nxt_res.wr_data[7] : nxt_res.wr_data[15];
         end
         cid_pkg::cid_bit_clr, cid_pkg::cid_bit_set: begin
            nxt_res.bit_wr = 1'b1;
            nxt_res.bit_val = (op == cid_pkg::cid_bit_set);
         end
         cid_pkg::cid_bit_copy, cid_pkg::cid_bit_copy_n, cid_pkg::cid_bit_and,
         cid_pkg::cid_bit_or, cid_pkg::cid_bit_xor: begin
            nxt_res.bit_wr = 1'b1;
            case (op)
               cid_pkg::cid_bit_copy: nxt_res.bit_val = in_ops.bit_src;
               cid_pkg::cid_bit_copy_n: nxt_res.bit_val = ~in_ops.bit_src;
               cid_pkg::cid_bit_and: nxt_res.bit_val = in_ops.bit_dst & in_ops.bit_src;
               cid_pkg::cid_bit_or: nxt_res.bit_val = in_ops.bit_dst | in_ops.bit_src;
               default: nxt_res.bit_val = in_ops.bit_dst ^ in_ops.bit_src;
            endcase
         end
         cid_pkg::cid_bit_cmp: begin
            nxt_res.flags_wr = 1'b1;
            nxt_res.flags.z = (in_ops.bit_dst == in_ops.bit_src);
            nxt_res.flags.c = in_ops.bit_dst & in_ops.bit_src;
         end
         cid_pkg::cid_field_hi, cid_pkg::cid_field_lo: begin
            nxt_res.wr_en = 1'b1;
            nxt_res.wr_data = a;
            if (op == cid_pkg::cid_field_hi) begin
               nxt_res.wr_data[15:8] = (a[15:8] & ~mask) | (in_ops.instr[7:0] & mask);
            end else begin
               nxt_res.wr_data[7:0] = (a[7:0] & ~mask) | (in_ops.instr[7:0] & mask);
            end
         end
         cid_pkg::cid_norm: begin
            nxt_res.wr_en = 1'b1;
            nxt_res.wr_data = {11'h000, norm_cnt};
         end
         cid_pkg::cid_shl, cid_pkg::cid_shr, cid_pkg::cid_rotl, cid_pkg::cid_rotr,
         cid_pkg::cid_sshr: begin
            nxt_res.wr_en = 1'b1;
            case (op)
               cid_pkg::cid_shl: nxt_res.wr_data = a << sh;
               cid_pkg::cid_shr: nxt_res.wr_data = a >> sh;
               cid_pkg::cid_rotl: nxt_res.wr_data = 16'({a, a} >> (5'h10 - {1'b0, sh}));
               cid_pkg::cid_rotr: nxt_res.wr_data = 16'({a, a} >> sh);
               default: nxt_res.wr_data = 16'($signed(a) >>> sh);
            endcase
         end
         cid_pkg::cid_mov, cid_pkg::cid_widen_s, cid_pkg::cid_widen_z: begin
            nxt_res.wr_en = 1'b1;
            nxt_res.wr_byte = is_byte && (op == cid_pkg::cid_mov);
            if (op == cid_pkg::cid_widen_s) begin
               nxt_res.wr_data = {{`CID_BYTE_SHIFT{b[7]}}, b[7:0]};
            end else if (op == cid_pkg::cid_widen_z) begin
               nxt_res.wr_data = {8'h00, b[7:0]};
            end else begin
               nxt_res.wr_data = b;
            end
         end
         cid_pkg::cid_jump: nxt_res.take_branch = 1'b1;
         cid_pkg::cid_jbit_set, cid_pkg::cid_jbit_set_clr: begin
            nxt_res.take_branch = in_ops.bit_dst;
            nxt_res.bit_wr = in_ops.bit_dst && (op == cid_pkg::cid_jbit_set_clr);
            nxt_res.bit_val = 1'b0;
         end
         cid_pkg::cid_jbit_clr, cid_pkg::cid_jbit_clr_set: begin
            nxt_res.take_branch = ~in_ops.bit_dst;
            nxt_res.bit_wr = ~in_ops.bit_dst && (op == cid_pkg::cid_jbit_clr_set);
            nxt_res.bit_val = 1'b1;
         end
         cid_pkg::cid_call: nxt_res.call = 1'b1;
         cid_pkg::cid_push_call: begin
            nxt_res.push_en = 1'b1;
            nxt_res.push_data = a;
            nxt_res.call = 1'b1;
         end
         cid_pkg::cid_push: begin
            nxt_res.push_en = 1'b1;
            nxt_res.push_data = a;
         end
         cid_pkg::cid_pop: nxt_res.pop_en = 1'b1;
         cid_pkg::cid_ctx_switch: begin
            nxt_res.push_en = 1'b1;
            nxt_res.push_data = a;
            nxt_res.wr_en = 1'b1;
            nxt_res.wr_data = b;
         end
         cid_pkg::cid_return, cid_pkg::cid_return_pop: begin
            nxt_res.ret = 1'b1;
            nxt_res.pop_en = (op == cid_pkg::cid_return_pop);
         end
         cid_pkg::cid_coproc: nxt_res.coproc = 1'b1;
         cid_pkg::cid_system, cid_pkg::cid_ext_seq: nxt_res.system = 1'b1;
         // Valid four-byte opcode with no effect on mode or state
         cid_pkg::cid_sleep_legacy: nxt_res.illegal = 1'b0;
         default: nxt_res.illegal = nxt_res.illegal;
      endcase
      if (!in_valid) begin
         nxt_res = '0;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         valid_ff <= 1'b0;
         res_ff <= '0;
      end else begin
         valid_ff <= nxt_valid;
         res_ff <= nxt_res;
      end
   end

   assign out_valid = valid_ff;
   assign out_res = res_ff;
endmodule
`default_nettype wire

// ==== hw/cid_defs.svh ====
// Field positions, lengths and step constants of the instruction decoder
`ifndef CID_DEFS_SVH
`define CID_DEFS_SVH
`define CID_OP_MSB 7
`define CID_OP_LSB 2
`define CID_BYTE_BIT 1
`define CID_LONG_BIT 0
`define CID_LEN_SHORT 3'h2
`define CID_LEN_LONG 3'h4
`define CID_STEP_ONE 16'h0001
`define CID_STEP_TWO 16'h0002
`define CID_BYTE_SHIFT 8
`define CID_WORD_MSB 15
`endif

// ==== hw/cid_pkg.sv ====
// Types shared by the instruction decoder and its neighbours
`default_nettype none
package cid_pkg;
   typedef enum logic [5:0] {
      cid_sum, cid_sum_carry, cid_diff, cid_diff_borrow,
      cid_prod, cid_prod_u, cid_quo, cid_quo_u, cid_quo_long, cid_quo_long_u,
      cid_compl, cid_negate, cid_and, cid_or, cid_xor,
      cid_bit_clr, cid_bit_set, cid_bit_copy, cid_bit_copy_n,
      cid_bit_and, cid_bit_or, cid_bit_xor, cid_bit_cmp, cid_field_hi, cid_field_lo,
      cid_cmp, cid_cmp_dec1, cid_cmp_dec2, cid_cmp_inc1, cid_cmp_inc2, cid_norm,
      cid_shl, cid_shr, cid_rotl, cid_rotr, cid_sshr, cid_mov, cid_widen_s, cid_widen_z,
      cid_jump, cid_jbit_set, cid_jbit_set_clr, cid_jbit_clr, cid_jbit_clr_set,
      cid_call, cid_push_call, cid_push, cid_pop, cid_ctx_switch,
      cid_return, cid_return_pop, cid_sleep_legacy, cid_nop, cid_coproc,
      cid_system, cid_ext_seq, cid_op_count
   } cid_op_t;

   // Operand values read from the register file for the current instruction
   typedef struct packed {
      logic [31:0] instr;
      logic [15:0] dst_val;
      logic [15:0] src_val;
      logic [31:0] pair_val;
      logic bit_dst;
      logic bit_src;
      logic carry_in;
   } cid_operands_t;

   typedef struct packed {
      logic v;
      logic c;
      logic z;
      logic n;
   } cid_flags_t;

   // Effects handed to register file, stack and fetch path
   typedef struct packed {
      logic wr_en;
      logic wr_byte;
      logic [15:0] wr_data;
      logic pair_wr;
      logic [31:0] pair_data;
      logic bit_wr;
      logic bit_val;
      logic flags_wr;
      cid_flags_t flags;
      logic take_branch;
      logic call;
      logic ret;
      logic [15:0] target;
      logic push_en;
      logic [15:0] push_data;
      logic pop_en;
      logic coproc;
      logic system;
      logic illegal;
      logic [7:0] sub_op;
   } cid_result_t;
endpackage
`default_nettype wire

// ==== test/cid_decoder_asserts.sv ====
// Port-level checks for the instruction decoder
`default_nettype none
module cid_decoder_asserts (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Fetch side
   input wire logic [7:0] fetch_byte,
   input wire logic [2:0] fetch_len,
   // Instruction in
   input wire logic in_valid,
   input wire cid_pkg::cid_operands_t in_ops,
   // Results
   input wire logic out_valid,
   input wire cid_pkg::cid_result_t out_res
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [5:0] op;
   logic [5:0] fop;
   assign op = in_ops.instr[31:26];
   assign fop = fetch_byte[7:2];
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   sequence s_take(logic [5:0] code);
      in_valid && op == code;
   endsequence
   sequence s_push_then_call;
      out_valid && out_res.push_en && out_res.call;
   endsequence
   AST_ANSWER: assert property (in_valid |=> out_valid)
      else $error("no result one cycle after valid");
   AST_QUIET: assert property (!in_valid |=> !out_valid && out_res == '0)
      else $error("result without instruction");
   AST_LEN_VAR: assert property (
      fop <= 6'h03 |-> fetch_len == (fetch_byte[0] ? 3'h4 : 3'h2))
      else $error("arith length wrong");
   AST_LEN_PROD: assert property (fop inside {[6'h04:6'h05]} |-> fetch_len == 3'h2)
      else $error("multiply length wrong");
   AST_LEN_SLEEP: assert property (
      fop == cid_pkg::cid_sleep_legacy |-> fetch_len == 3'h4)
      else $error("sleep opcode length wrong");
   AST_LEN_COPROC: assert property (fop == cid_pkg::cid_coproc |-> fetch_len == 3'h4)
      else $error("coprocessor length wrong");
   AST_LEN_SET: assert property (fetch_len inside {3'h2, 3'h4})
      else $error("length neither two nor four");
   AST_SLEEP_IDLE: assert property (s_take(cid_pkg::cid_sleep_legacy) |=> out_valid &&
      !(out_res.wr_en | out_res.pair_wr | out_res.push_en | out_res.pop_en | out_res.illegal))
      else $error("sleep opcode had an effect");
   AST_DEC1: assert property (s_take(cid_pkg::cid_cmp_dec1) |=>
      out_res.wr_en && out_res.wr_data == $past(in_ops.dst_val) - 16'h0001)
      else $error("decrement by one wrong");
   AST_INC2: assert property (s_take(cid_pkg::cid_cmp_inc2) |=>
      out_res.wr_en && out_res.wr_data == $past(in_ops.dst_val) + 16'h0002)
      else $error("increment by two wrong");
   AST_PUSH_CALL: assert property (s_take(cid_pkg::cid_push_call) |=>
      s_push_then_call ##0 out_res.push_data == $past(in_ops.dst_val))
      else $error("push and call wrong");
endmodule
bind cid_decoder cid_decoder_asserts u_asserts (.clk(clk), .reset(reset),
   .fetch_byte(fetch_byte), .fetch_len(fetch_len), .in_valid(in_valid),
   .in_ops(in_ops), .out_valid(out_valid), .out_res(out_res));
`default_nettype wire

// ==== test/cid_fetch_model.sv ====
// Fetch path and program memory stepping by decoded length
`default_nettype none
module cid_fetch_model (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Fetch control
   input wire logic run,
   input wire logic [2:0] fetch_len,
   output logic [7:0] fetch_byte,
   output logic [7:0] ip
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [256];
   logic [7:0] ip_ff;
   logic [7:0] nxt_ip;
   // Unused bytes read as an illegal code, never as a stale opcode
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'hFF;
      end
   end
   always_comb begin
      nxt_ip = ip_ff;
      if (run) begin
         nxt_ip = ip_ff + {5'h00, fetch_len};
      end
   end
   always_ff @(posedge clk) begin
      ip_ff <= reset ? 8'h00 : nxt_ip;
   end
   assign fetch_byte = mem[ip_ff];
   assign ip = ip_ff;
endmodule
`default_nettype wire

// ==== test/cpu_instruction_decode_tb_top.sv ====
// Self-checking bench for the instruction decoder
`default_nettype none
module cpu_instruction_decode_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic run = 1'b0;
   logic in_valid = 1'b0;
   cid_pkg::cid_operands_t in_ops = '0;
   logic [7:0] fetch_byte;
   logic [7:0] ip;
   logic [2:0] fetch_len;
   logic out_valid;
   cid_pkg::cid_result_t res;
   int n_errors = 0;
   int checks_done = 0;
   int cycles = 0;

   cid_decoder dut (.clk(clk), .reset(reset), .fetch_byte(fetch_byte), .fetch_len(fetch_len),
      .in_valid(in_valid), .in_ops(in_ops), .out_valid(out_valid), .out_res(res));
   cid_fetch_model fetch (.clk(clk), .reset(reset), .run(run), .fetch_len(fetch_len),
      .fetch_byte(fetch_byte), .ip(ip));

   always #5 clk = ~clk;

   // Whole run needs under two hundred cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         n_errors++;
         close_out();
      end
   end

   task automatic close_out();
      if (n_errors == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(string n, logic [31:0] s, logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask

   function automatic logic [2:0] exp_len(logic [5:0] c, logic lng);
      if (c >= 6'h38) return 3'h2;
      if (c inside {[6'h00:6'h03], [6'h0C:6'h0E], [6'h19:6'h1D], [6'h24:6'h26], 6'h37})
         return lng ? 3'h4 : 3'h2;
      if (c inside {[6'h04:6'h0B], [6'h0F:6'h10], [6'h1E:6'h23], [6'h2E:6'h2F],
         [6'h31:6'h32], 6'h34})
         return 3'h2;
      return 3'h4;
   endfunction

   // One instruction in, result sampled once it has settled
   task automatic exec(cid_pkg::cid_op_t op, logic [1:0] form, logic [15:0] d, logic [15:0] s,
      logic [31:0] p = 32'h0000_0000, logic [2:0] bits = 3'b000, logic [15:0] imm = 16'h0000);
      @(posedge clk);
      in_valid <= 1'b1;
      in_ops <= '{instr: {op, form, 8'h5A, imm}, dst_val: d, src_val: s, pair_val: p,
         bit_dst: bits[2], bit_src: bits[1], carry_in: bits[0]};
      @(posedge clk);
      in_valid <= 1'b0;
      #1;
      chk("out_valid", 32'(out_valid), 32'h0000_0001);
   endtask

   task automatic t_lengths();
      logic [7:0] addr [65];
      logic [2:0] el [64];
      addr[0] = 8'h00;
      for (int i = 0; i < 64; i++) begin
         el[i] = exp_len(6'(i), i[0]);
         fetch.mem[addr[i]] = {6'(i), 1'b0, i[0]};
         addr[i + 1] = addr[i] + {5'h00, el[i]};
      end
      @(posedge clk);
      run <= 1'b1;
      for (int i = 0; i < 64; i++) begin
         #1;
         chk("fetch_len", 32'(fetch_len), 32'(el[i]));
         chk("ip", 32'(ip), 32'(addr[i]));
         @(posedge clk);
      end
      run <= 1'b0;
   endtask

   task automatic t_arith();
      exec(cid_pkg::cid_sum_carry, 2'b00, 16'hFFFF, 16'h0001, '0, 3'b001);
      chk("sum_carry", 32'(res.wr_data), 32'h0000_0001);
      exec(cid_pkg::cid_sum, 2'b10, 16'h12F0, 16'h0010);
      chk("sum_byte", 32'({res.wr_byte, res.wr_data}), 32'h0001_0000);
      exec(cid_pkg::cid_diff_borrow, 2'b01, 16'h0005, 16'h0003, '0, 3'b001);
      chk("diff_borrow", 32'(res.wr_data), 32'h0000_0001);
      exec(cid_pkg::cid_diff, 2'b10, 16'h0034, 16'h0012);
      chk("diff_byte", 32'({res.wr_byte, res.wr_data}), 32'h0001_0022);
   endtask

   task automatic t_muldiv();
      exec(cid_pkg::cid_prod, 2'b00, 16'hFFFF, 16'h0002);
      chk("prod", res.pair_data, 32'hFFFF_FFFE);
      exec(cid_pkg::cid_prod_u, 2'b00, 16'hFFFF, 16'h0002);
      chk("prod_u", res.pair_data, 32'h0001_FFFE);
      exec(cid_pkg::cid_quo, 2'b00, 16'h0002, 16'h0002, 32'h0000_FFF9);
      chk("quo", res.pair_data, 32'hFFFF_FFFD);
      exec(cid_pkg::cid_quo_u, 2'b00, 16'h0000, 16'h0000, 32'h0000_0064);
      chk("div_zero", 32'({res.pair_wr, res.flags.v}), 32'h0000_0001);
      exec(cid_pkg::cid_quo_long_u, 2'b00, 16'h0002, 16'h0002, 32'h0001_0001);
      chk("quo_long_u", res.pair_data, 32'h0001_8000);
      exec(cid_pkg::cid_quo_long, 2'b00, 16'hFFFE, 16'hFFFE, 32'hFFFF_FFF8);
      chk("quo_long", res.pair_data, 32'h0000_0004);
   endtask

   task automatic t_step();
      cid_pkg::cid_op_t ops [4] = '{cid_pkg::cid_cmp_dec1, cid_pkg::cid_cmp_dec2,
         cid_pkg::cid_cmp_inc1, cid_pkg::cid_cmp_inc2};
      logic [15:0] want [4] = '{16'h000F, 16'h000E, 16'h0011, 16'h0012};
      for (int i = 0; i < 4; i++) begin
         exec(ops[i], 2'b01, 16'h0010, 16'h0010);
         chk("step", 32'({res.flags.z, res.wr_data}), 32'({1'b1, want[i]}));
      end
   endtask

   task automatic t_shift();
      exec(cid_pkg::cid_norm, 2'b00, 16'h0000, 16'h0001);
      chk("norm_one", 32'(res.wr_data), 32'h0000_000F);
      exec(cid_pkg::cid_norm, 2'b00, 16'h0000, 16'h8000);
      chk("norm_top", 32'(res.wr_data), 32'h0000_0000);
      exec(cid_pkg::cid_sshr, 2'b00, 16'h8000, 16'h0004);
      chk("sshr", 32'(res.wr_data), 32'h0000_F800);
      exec(cid_pkg::cid_widen_s, 2'b00, 16'h0080, 16'h0080);
      chk("widen_s", 32'(res.wr_data), 32'h0000_FF80);
      exec(cid_pkg::cid_widen_z, 2'b00, 16'h0080, 16'h0080);
      chk("widen_z", 32'(res.wr_data), 32'h0000_0080);
      exec(cid_pkg::cid_rotl, 2'b00, 16'h8421, 16'h0004);
      chk("rotl", 32'(res.wr_data), 32'h0000_4218);
      exec(cid_pkg::cid_rotr, 2'b00, 16'h8421, 16'h0004);
      chk("rotr", 32'(res.wr_data), 32'h0000_1842);
      exec(cid_pkg::cid_shl, 2'b00, 16'h8421, 16'h0004);
      chk("shl", 32'(res.wr_data), 32'h0000_4210);
      exec(cid_pkg::cid_shr, 2'b00, 16'h8421, 16'h0004);
      chk("shr", 32'(res.wr_data), 32'h0000_0842);
   endtask

   task automatic t_bits();
      exec(cid_pkg::cid_jbit_set_clr, 2'b00, '0, '0, '0, 3'b100, 16'h0040);
      chk("jb_taken", 32'({res.take_branch, res.bit_wr, res.bit_val, res.target}),
         32'h0006_0040);
      exec(cid_pkg::cid_jbit_set_clr, 2'b00, '0, '0, '0, 3'b000, 16'h0040);
      chk("jb_not", 32'({res.take_branch, res.bit_wr}), 32'h0000_0000);
      exec(cid_pkg::cid_jbit_clr_set, 2'b00, '0, '0, '0, 3'b000, 16'h0040);
      chk("jnb", 32'({res.take_branch, res.bit_wr, res.bit_val}), 32'h0000_0007);
      exec(cid_pkg::cid_bit_copy_n, 2'b00, '0, '0, '0, 3'b010);
      chk("copy_n", 32'({res.bit_wr, res.bit_val}), 32'h0000_0002);
      exec(cid_pkg::cid_bit_xor, 2'b00, '0, '0, '0, 3'b100);
      chk("bit_xor", 32'({res.bit_wr, res.bit_val}), 32'h0000_0003);
      exec(cid_pkg::cid_bit_and, 2'b00, '0, '0, '0, 3'b110);
      chk("bit_and", 32'({res.bit_wr, res.bit_val}), 32'h0000_0003);
      exec(cid_pkg::cid_bit_or, 2'b00, '0, '0, '0, 3'b000);
      chk("bit_or", 32'({res.bit_wr, res.bit_val}), 32'h0000_0002);
      exec(cid_pkg::cid_field_lo, 2'b00, 16'h1234, '0, '0, 3'b000, 16'h0FA5);
      chk("field_lo", 32'(res.wr_data), 32'h0000_1235);
      exec(cid_pkg::cid_field_hi, 2'b00, 16'h1234, '0, '0, 3'b000, 16'hF0A5);
      chk("field_hi", 32'(res.wr_data), 32'h0000_A234);
   endtask

   task automatic t_stack();
      exec(cid_pkg::cid_push_call, 2'b00, 16'h1357, '0, '0, 3'b000, 16'h0200);
      chk("push_call", 32'({res.push_en, res.call, res.push_data}), 32'h0003_1357);
      exec(cid_pkg::cid_ctx_switch, 2'b00, 16'h1357, 16'h2468);
      chk("ctx_push", 32'({res.push_en, res.push_data}), 32'h0001_1357);
      chk("ctx_load", 32'({res.wr_en, res.wr_data}), 32'h0001_2468);
      exec(cid_pkg::cid_return_pop, 2'b00, '0, '0);
      chk("ret_pop", 32'({res.ret, res.pop_en}), 32'h0000_0003);
      exec(cid_pkg::cid_return, 2'b00, '0, '0);
      chk("ret", 32'({res.ret, res.pop_en}), 32'h0000_0002);
      exec(cid_pkg::cid_sleep_legacy, 2'b00, 16'h1111, 16'h2222);
      chk("sleep", 32'({res.wr_en, res.pair_wr, res.push_en, res.pop_en, res.call, res.ret,
         res.take_branch, res.system, res.illegal, res.flags_wr}), 32'h0000_0000);
      exec(cid_pkg::cid_coproc, 2'b00, '0, '0);
      chk("coproc", 32'({res.coproc, res.sub_op}), 32'h0000_015A);
      exec(cid_pkg::cid_op_count, 2'b00, 16'h0001, 16'h0001);
      chk("illegal", 32'({res.illegal, res.wr_en}), 32'h0000_0002);
   endtask

   initial begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      t_lengths();
      t_arith();
      t_muldiv();
      t_step();
      t_shift();
      t_bits();
      t_stack();
      close_out();
   end
endmodule
`default_nettype wire
